/* dcp_pkg.sv */
// Purpose: Constants for the DAC configuration, power and transmit-enable register bank
// Assumes: One DAC clock domain; serial port pins sampled as synchronous inputs
// Notes:   Offsets, field positions, reset values and delay counts
package dcp_pkg;

	// Register offsets on the serial port
	localparam logic [6:0] DCP_ADDR_COMM  = 7'h00;
	localparam logic [6:0] DCP_ADDR_POWER = 7'h01;
	localparam logic [6:0] DCP_ADDR_TXEN  = 7'h02;

	// Communication register fields
	localparam int DCP_COMM_SDIO_BIDIR = 7;
	localparam int DCP_COMM_LSB_FIRST  = 6;
	localparam int DCP_COMM_SOFT_RESET = 5;

	// Power control register fields
	localparam int DCP_PWR_I_DAC   = 7;
	localparam int DCP_PWR_Q_DAC   = 6;
	localparam int DCP_PWR_DATA_RX = 5;
	localparam int DCP_PWR_AUX_ADC = 4;
	localparam int DCP_PWR_AUX_REF = 3;
	localparam int DCP_PWR_CLOCKS  = 2;

	// Transmit-enable register fields
	localparam int DCP_TX_EXT_LEN  = 6;
	localparam int DCP_TX_EXT_EN   = 5;
	localparam int DCP_TX_PD_VREF  = 4;
	localparam int DCP_TX_PD_PLL   = 3;
	localparam int DCP_TX_PD_DACS  = 2;
	localparam int DCP_TX_PD_FIFO  = 1;
	localparam int DCP_TX_PD_FILT  = 0;

	// Reset values and implemented-bit masks
	localparam logic [7:0] DCP_COMM_RESET  = 8'h00;
	localparam logic [7:0] DCP_COMM_MASK   = 8'hE0;
	localparam logic [7:0] DCP_POWER_RESET = 8'h10;
	localparam logic [7:0] DCP_POWER_MASK  = 8'hFC;
	localparam logic [7:0] DCP_TXEN_RESET  = 8'h00;
	localparam logic [7:0] DCP_TXEN_MASK   = 8'h7F;

	// Transmit start timing
	localparam int         DCP_DAC_DIV        = 64;
	localparam logic [3:0] DCP_FIXED_CYCLES   = 4'hA;
	localparam logic [4:0] DCP_EDGES_SHORT    = 5'h01;
	localparam logic [4:0] DCP_EDGES_EXT_LOW  = 5'h0C;
	localparam logic [4:0] DCP_EDGES_EXT_HIGH = 5'h13;

	// Serial port phases, one-hot
	typedef enum logic [2:0] {
		DCP_SPI_INSTR = 3'b001,
		DCP_SPI_DATA  = 3'b010,
		DCP_SPI_DONE  = 3'b100
	} dcp_spi_state_t;

	// Transmit start sequence, one-hot
	typedef enum logic [3:0] {
		DCP_TX_OFF   = 4'b0001,
		DCP_TX_FIXED = 4'b0010,
		DCP_TX_EDGES = 4'b0100,
		DCP_TX_ON    = 4'b1000
	} dcp_tx_state_t;

endpackage : dcp_pkg

/* dcp_regs.sv */
// Purpose: Serial-port register bank for comm, power and transmit-enable control
// Assumes: spi_* and transmit_enable_pin are synchronous to clk; clk is the DAC clock
// Notes:   One data byte per serial transaction; bit 7 of instruction is read/not-write
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Pin-direction bit 0 keeps data pin input only; 1 allows readback drive.
// - Bit-order bit 0 shifts MSB first; 1 shifts LSB first.
// - Soft reset bit holds device in reset until written back to 0.
// - Power bits 7 and 6 power down I and Q DAC cores; reset 0.
// - Power bit 5 powers down data receiver; reset 0.
// - Power bit 4 powers down auxiliary ADC; resets to 1.
// - Power bit 3 powers down auxiliary DACs and reference together.
// - Power bit 2 powers down the clocks; reset 0.
// - Extended delay picks 12 or 19 divided-clock edges by bit 6.
// - Extended delay off gives 1 divided-clock edge start delay.
// - Bit 6 matters only while extended delay bit 5 is set.
// - Every start delay adds a fixed 10 DAC clock cycles.
// - Transmit bit 4 powers down reference while transmit-enable pin low.
// - Transmit bit 3 powers down PLL while transmit-enable pin low.
// - Transmit bit 2 powers down DAC cores while transmit-enable pin low.
// - Transmit bit 1 powers down FIFO while transmit-enable pin low.
// - Transmit bit 0 powers down filters while transmit-enable pin low.
module dcp_regs
	import dcp_pkg::*;
#(
	parameter int DAC_DIV = DCP_DAC_DIV
)(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic spi_sclk,
	input  wire logic spi_csb,
	input  wire logic spi_sdio_in,
	output var  logic spi_sdio_out,
	output var  logic spi_sdio_oe,
	input  wire logic transmit_enable_pin,
	output var  logic soft_reset,
	output var  logic dac_div_clk,
	output var  logic tx_active,
	output var  logic pd_i_dac,
	output var  logic pd_q_dac,
	output var  logic pd_data_rx,
	output var  logic pd_aux_adc,
	output var  logic pd_aux_dacs,
	output var  logic pd_vref,
	output var  logic pd_clocks,
	output var  logic pd_pll,
	output var  logic pd_fifo,
	output var  logic pd_filters
);

	localparam int DW = $clog2(DAC_DIV);

	logic [7:0]     comm_reg;
	logic [7:0]     power_reg;
	logic [7:0]     txen_reg;
	dcp_spi_state_t spi_state;
	logic           sclk_q;
	logic           sclk_rise;
	logic           sclk_fall;
	logic [2:0]     bit_cnt;
	logic [7:0]     in_shift;
	logic [7:0]     next_in_shift;
	logic [7:0]     out_shift;
	logic           rd_cmd;
	logic [6:0]     addr;
	logic           wr_strobe;
	logic           lsb_first;
	logic [DW-1:0]  div_cnt;
	logic           div_edge;
	dcp_tx_state_t  tx_state;
	logic [3:0]     fixed_cnt;
	logic [4:0]     edge_cnt;
	logic [4:0]     edge_target;
	logic [4:0]     tx_gated;

	// Readback value of a register, undefined bits zero
	function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] p, input logic [7:0] t);
		case (a)
			DCP_ADDR_COMM:  read_reg = c & DCP_COMM_MASK;
			DCP_ADDR_POWER: read_reg = p & DCP_POWER_MASK;
			DCP_ADDR_TXEN:  read_reg = t & DCP_TXEN_MASK;
			default:        read_reg = 8'h00;
		endcase
	endfunction : read_reg

	// Bit presented first or next on the data pin
	function automatic logic first_bit(input logic [7:0] v, input logic lsb);
		first_bit = lsb ? v[0] : v[7];
	endfunction : first_bit

	////////////////////////////////////////////////////////////////////////////
	// Serial port
	////////////////////////////////////////////////////////////////////////////

	assign sclk_rise = spi_sclk & ~sclk_q;
	assign sclk_fall = ~spi_sclk & sclk_q;
	assign lsb_first = comm_reg[DCP_COMM_LSB_FIRST];

	always_comb
	begin
		if (lsb_first)
			next_in_shift = {spi_sdio_in, in_shift[7:1]};
		else
			next_in_shift = {in_shift[6:0], spi_sdio_in};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			sclk_q <= 1'b0;
		else
			sclk_q <= spi_sclk;
	end

	always_ff @(posedge clk)
	begin
		if (reset || spi_csb)
		begin
			spi_state <= DCP_SPI_INSTR;
			bit_cnt   <= 3'h0;
			in_shift  <= 8'h00;
			rd_cmd    <= 1'b0;
			addr      <= 7'h00;
		end
		else if (sclk_rise)
		begin
			in_shift <= next_in_shift;
			bit_cnt  <= bit_cnt + 3'h1;
			case (spi_state)
				DCP_SPI_INSTR:
				begin
					if (bit_cnt == 3'h7)
					begin
						rd_cmd    <= next_in_shift[7];
						addr      <= next_in_shift[6:0];
						spi_state <= DCP_SPI_DATA;
					end
				end
				DCP_SPI_DATA:
				begin
					if (bit_cnt == 3'h7)
						spi_state <= DCP_SPI_DONE;
				end
				DCP_SPI_DONE:
					spi_state <= DCP_SPI_DONE;
				default:
					spi_state <= DCP_SPI_INSTR;
			endcase
		end
	end

	assign wr_strobe = sclk_rise && !spi_csb && (spi_state == DCP_SPI_DATA)
		&& (bit_cnt == 3'h7) && !rd_cmd;

	// Readback shifter, loaded after instruction, advanced on falling edge
	always_ff @(posedge clk)
	begin
		if (reset || spi_csb)
			out_shift <= 8'h00;
		else if (sclk_rise && spi_state == DCP_SPI_INSTR && bit_cnt == 3'h7)
			out_shift <= read_reg(next_in_shift[6:0], comm_reg, power_reg, txen_reg);
		else if (sclk_fall && spi_state == DCP_SPI_DATA && bit_cnt != 3'h0)
		begin
			if (lsb_first)
				out_shift <= {1'b0, out_shift[7:1]};
			else
				out_shift <= {out_shift[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			spi_sdio_out <= 1'b0;
			spi_sdio_oe  <= 1'b0;
		end
		else
		begin
			spi_sdio_out <= first_bit(out_shift, lsb_first);
			spi_sdio_oe  <= comm_reg[DCP_COMM_SDIO_BIDIR] && !spi_csb && rd_cmd
				&& (spi_state == DCP_SPI_DATA);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk)
	begin
		if (reset)
			comm_reg <= DCP_COMM_RESET;
		else if (wr_strobe && addr == DCP_ADDR_COMM)
			comm_reg <= next_in_shift & DCP_COMM_MASK;
	end

	// soft reset holds others at default
	always_ff @(posedge clk)
	begin
		if (reset || comm_reg[DCP_COMM_SOFT_RESET])
			power_reg <= DCP_POWER_RESET;
		else if (wr_strobe && addr == DCP_ADDR_POWER)
			power_reg <= next_in_shift & DCP_POWER_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (reset || comm_reg[DCP_COMM_SOFT_RESET])
			txen_reg <= DCP_TXEN_RESET;
		else if (wr_strobe && addr == DCP_ADDR_TXEN)
			txen_reg <= next_in_shift & DCP_TXEN_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			soft_reset <= 1'b0;
		else
			soft_reset <= comm_reg[DCP_COMM_SOFT_RESET];
	end

	////////////////////////////////////////////////////////////////////////////
	// Divided clock and transmit start
	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			div_cnt     <= '0;
			dac_div_clk <= 1'b0;
		end
		else
		begin
			div_cnt     <= div_cnt + DW'(1);
			dac_div_clk <= (div_cnt + DW'(1)) >= DW'(DAC_DIV / 2);
		end
	end

	assign div_edge = (div_cnt == DW'(DAC_DIV / 2 - 1));

	always_comb
	begin
		if (!txen_reg[DCP_TX_EXT_EN])
			edge_target = DCP_EDGES_SHORT;
		else if (txen_reg[DCP_TX_EXT_LEN])
			edge_target = DCP_EDGES_EXT_HIGH;
		else
			edge_target = DCP_EDGES_EXT_LOW;
	end

	always_ff @(posedge clk)
	begin
		if (reset || comm_reg[DCP_COMM_SOFT_RESET] || !transmit_enable_pin)
		begin
			tx_state  <= DCP_TX_OFF;
			fixed_cnt <= 4'h0;
			edge_cnt  <= 5'h00;
		end
		else
		begin
			case (tx_state)
				DCP_TX_OFF:
				begin
					fixed_cnt <= 4'h1;
					tx_state  <= DCP_TX_FIXED;
				end
				DCP_TX_FIXED:
				begin
					fixed_cnt <= fixed_cnt + 4'h1;
					if (fixed_cnt == DCP_FIXED_CYCLES)
						tx_state <= DCP_TX_EDGES;
				end
				DCP_TX_EDGES:
				begin
					if (div_edge)
					begin
						edge_cnt <= edge_cnt + 5'h01;
						if (edge_cnt + 5'h01 >= edge_target)
							tx_state <= DCP_TX_ON;
					end
				end
				DCP_TX_ON:
					tx_state <= DCP_TX_ON;
				default:
					tx_state <= DCP_TX_OFF;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			tx_active <= 1'b0;
		else
			tx_active <= (tx_state == DCP_TX_ON) && transmit_enable_pin;
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-down outputs
	////////////////////////////////////////////////////////////////////////////

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_tx_gate
			assign tx_gated[gi] = txen_reg[gi] & ~transmit_enable_pin;
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pd_i_dac    <= DCP_POWER_RESET[DCP_PWR_I_DAC];
			pd_q_dac    <= DCP_POWER_RESET[DCP_PWR_Q_DAC];
			pd_data_rx  <= DCP_POWER_RESET[DCP_PWR_DATA_RX];
			pd_aux_adc  <= DCP_POWER_RESET[DCP_PWR_AUX_ADC];
			pd_aux_dacs <= DCP_POWER_RESET[DCP_PWR_AUX_REF];
			pd_clocks   <= DCP_POWER_RESET[DCP_PWR_CLOCKS];
			pd_vref     <= DCP_POWER_RESET[DCP_PWR_AUX_REF];
			pd_pll      <= 1'b0;
			pd_fifo     <= 1'b0;
			pd_filters  <= 1'b0;
		end
		else
		begin
			pd_i_dac    <= power_reg[DCP_PWR_I_DAC] | tx_gated[DCP_TX_PD_DACS];
			pd_q_dac    <= power_reg[DCP_PWR_Q_DAC] | tx_gated[DCP_TX_PD_DACS];
			pd_data_rx  <= power_reg[DCP_PWR_DATA_RX];
			pd_aux_adc  <= power_reg[DCP_PWR_AUX_ADC];
			pd_aux_dacs <= power_reg[DCP_PWR_AUX_REF];
			pd_clocks   <= power_reg[DCP_PWR_CLOCKS];
			pd_vref     <= power_reg[DCP_PWR_AUX_REF] | tx_gated[DCP_TX_PD_VREF];
			pd_pll      <= tx_gated[DCP_TX_PD_PLL];
			pd_fifo     <= tx_gated[DCP_TX_PD_FIFO];
			pd_filters  <= tx_gated[DCP_TX_PD_FILT];
		end
	end

endmodule : dcp_regs

`default_nettype wire

/* dcp_regs_properties.sv */
// Purpose: Port checks for dcp_regs
// Assumes: One clock, sync reset
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module dcp_props #(
	parameter int DAC_DIV = 64
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic spi_csb,
	input wire logic spi_sdio_oe,
	input wire logic transmit_enable_pin,
	input wire logic soft_reset,
	input wire logic dac_div_clk,
	input wire logic tx_active,
	input wire logic pd_i_dac,
	input wire logic pd_aux_adc,
	input wire logic pd_aux_dacs,
	input wire logic pd_vref,
	input wire logic pd_clocks,
	input wire logic pd_pll,
	input wire logic pd_fifo,
	input wire logic pd_filters
);
	localparam int HALF = DAC_DIV / 2;
	int hi_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Cycles since transmit pin rose
	always_ff @(posedge clk)
	begin
		if (reset || !transmit_enable_pin)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end
	a_reset_values: assert property ($fell(reset) |-> pd_aux_adc && !pd_i_dac
		&& !pd_clocks && !tx_active && !soft_reset) else $error("bad reset state");
	a_pin_low_pd: assert property ((pd_pll || pd_fifo || pd_filters)
		|-> !$past(transmit_enable_pin)) else $error("pd while pin high");
	a_vref_pin_low: assert property ((pd_vref && !pd_aux_dacs)
		|-> !$past(transmit_enable_pin)) else $error("vref pd while pin high");
	a_tx_pin_clear: assert property (!transmit_enable_pin |=> !tx_active)
		else $error("tx stays active");
	a_tx_start_window: assert property ($rose(tx_active) |-> hi_cnt >= 11
		&& hi_cnt <= 20 * DAC_DIV + 14) else $error("tx start time");
	a_div_half_period: assert property ($changed(dac_div_clk)
		|-> ##HALF $changed(dac_div_clk)) else $error("div clock period");
	a_oe_cs_drop: assert property (spi_csb |=> !spi_sdio_oe)
		else $error("pin driven without select");
	a_soft_hold: assert property (soft_reset && $past(soft_reset) && $past(soft_reset, 2)
		|-> pd_aux_adc && !pd_i_dac && !tx_active) else $error("soft reset state");
	a_tx_pd_off: assert property (tx_active |-> !pd_pll && !pd_fifo && !pd_filters)
		else $error("pd while transmitting");
endmodule : dcp_props
bind dcp_regs dcp_props #(.DAC_DIV(DAC_DIV)) dcp_props_i (.clk(clk), .reset(reset),
	.spi_csb(spi_csb), .spi_sdio_oe(spi_sdio_oe), .transmit_enable_pin(transmit_enable_pin),
	.soft_reset(soft_reset), .dac_div_clk(dac_div_clk), .tx_active(tx_active),
	.pd_i_dac(pd_i_dac), .pd_aux_adc(pd_aux_adc), .pd_aux_dacs(pd_aux_dacs),
	.pd_vref(pd_vref), .pd_clocks(pd_clocks), .pd_pll(pd_pll), .pd_fifo(pd_fifo),
	.pd_filters(pd_filters));
`default_nettype wire

/* dcp_host.sv */
// Purpose: Serial host model
// Assumes: Pins change after clk rise
// Notes:   lsb picks bit order
`timescale 1ns/1ps
`default_nettype none
module dcp_host (
	input  wire logic clk,
	input  wire logic spi_sdio_out,
	input  wire logic spi_sdio_oe,
	output var  logic spi_sclk,
	output var  logic spi_csb,
	output wire logic spi_sdio_in
);
	logic lsb = 1'b0;
	logic drv = 1'b0;
	initial
	begin
		spi_sclk = 1'b0;
		spi_csb = 1'b1;
	end
	assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : drv;
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] w;
		int bi;
		w = {rd, a, d};
		q = 8'h00;
		@(posedge clk);
		spi_csb <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			bi = lsb ? i % 8 : 7 - i % 8;
			spi_sclk <= 1'b0;
			drv <= (rd && i > 7) ? ~drv : w[bi + (i < 8 ? 8 : 0)];
			repeat (3) @(posedge clk);
			if (i > 7)
				q[bi] = spi_sdio_in;
			spi_sclk <= 1'b1;
			repeat (2) @(posedge clk);
		end
		spi_sclk <= 1'b0;
		repeat (2) @(posedge clk);
		spi_csb <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : xfer
endmodule : dcp_host
`default_nettype wire

/* dcp_regs_tb.sv */
// Purpose: Self-checking bench for dcp_regs
// Assumes: Short divider
// Notes:   Host model drives the serial port
`timescale 1ns/1ps
`default_nettype none
module dcp_regs_tb;
	localparam int DIV = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic pin = 1'b0;
	wire logic sclk, csb, sdi;
	logic sdo, oe, srst, dclk, act, p_i, p_q, p_rx, p_adc, p_aux, p_vr, p_ck, p_pll, p_ff, p_fl;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	logic oe_seen = 1'b0;
	logic [7:0] q;
	always #50 clk = ~clk;
	always @(posedge clk)
		if (oe === 1'b1)
			oe_seen <= 1'b1;
	dcp_host dcp_host_i (.clk(clk), .spi_sdio_out(sdo), .spi_sdio_oe(oe), .spi_sclk(sclk),
		.spi_csb(csb), .spi_sdio_in(sdi));
	dcp_regs #(.DAC_DIV(DIV)) dcp_regs_i (.clk(clk), .reset(reset), .spi_sclk(sclk),
		.spi_csb(csb), .spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(oe),
		.transmit_enable_pin(pin), .soft_reset(srst), .dac_div_clk(dclk), .tx_active(act),
		.pd_i_dac(p_i), .pd_q_dac(p_q), .pd_data_rx(p_rx), .pd_aux_adc(p_adc),
		.pd_aux_dacs(p_aux), .pd_vref(p_vr), .pd_clocks(p_ck), .pd_pll(p_pll),
		.pd_fifo(p_ff), .pd_filters(p_fl));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		dcp_host_i.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		dcp_host_i.xfer(1'b1, a, 8'h00, q);
		chk(q, e);
	endtask : rd
	task automatic end_sim;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic t_rst;
		int n;
		chk({p_i, p_q, p_rx, p_adc, p_aux, p_ck, p_pll, p_ff}, 8'h10);
		wr(7'h00, 8'h80);
		rd(7'h00, 8'h80);
		rd(7'h01, 8'h10);
		rd(7'h02, 8'h00);
		rd(7'h05, 8'h00);
		chk({7'h00, oe_seen}, 8'h01);
		n = 0;
		repeat (2 * DIV)
		begin
			@(negedge clk);
			n += dclk;
		end
		chk(n[7:0], 8'(DIV));
		$display("done reset");
	endtask : t_rst
	task automatic t_pwr;
		logic [7:0] v [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'hFF, 8'h00};
		foreach (v[k])
		begin
			wr(7'h01, v[k]);
			chk({p_i, p_q, p_rx, p_adc, p_aux, p_ck, p_vr, 1'b0}, {v[k][7:2], v[k][3], 1'b0});
			rd(7'h01, v[k] & 8'hFC);
		end
		$display("done power");
	endtask : t_pwr
	task automatic t_txpd;
		logic [7:0] v [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
		foreach (v[k])
		begin
			wr(7'h02, v[k]);
			chk({3'h0, p_vr, p_pll, p_i, p_ff, p_fl}, v[k]);
			chk({7'h00, p_q}, {7'h00, v[k][2]});
		end
		wr(7'h02, 8'h1F);
		pin <= 1'b1;
		repeat (3) @(negedge clk);
		chk({3'h0, p_vr, p_pll, p_i, p_ff, p_fl}, 8'h00);
		chk({7'h00, p_q}, 8'h00);
		@(posedge clk) pin <= 1'b0;
		repeat (2) @(negedge clk);
		chk({3'h0, p_vr, p_pll, p_i, p_ff, p_fl}, 8'h1F);
		$display("done txen pd");
	endtask : t_txpd
	task automatic t_dly;
		logic [7:0] v [4] = '{8'h00, 8'h40, 8'h20, 8'h60};
		int nv [4] = '{1, 1, 12, 19};
		int n;
		int lo;
		foreach (v[k])
		begin
			wr(7'h02, v[k]);
			@(posedge clk) pin <= 1'b1;
			n = 0;
			while (act !== 1'b1 && n < 300)
			begin
				@(negedge clk);
				n++;
			end
			lo = 10 + (nv[k] - 1) * DIV;
			chk({7'h00, n >= lo && n <= lo + DIV + 6}, 8'h01);
			@(posedge clk) pin <= 1'b0;
			repeat (2) @(negedge clk);
			chk({7'h00, act}, 8'h00);
		end
		$display("done delay");
	endtask : t_dly
	task automatic t_lsb;
		wr(7'h00, 8'hC0);
		dcp_host_i.lsb = 1'b1;
		wr(7'h01, 8'hA4);
		chk({p_i, p_q, p_rx, p_adc, p_aux, p_ck, 2'b00}, 8'hA4);
		rd(7'h01, 8'hA4);
		wr(7'h00, 8'h80);
		dcp_host_i.lsb = 1'b0;
		rd(7'h00, 8'h80);
		$display("done order");
	endtask : t_lsb
	task automatic t_soft;
		wr(7'h00, 8'hA0);
		chk({7'h00, srst}, 8'h01);
		pin <= 1'b1;
		wr(7'h01, 8'h80);
		chk({7'h00, p_i}, 8'h00);
		chk({7'h00, act}, 8'h00);
		pin <= 1'b0;
		rd(7'h01, 8'h10);
		wr(7'h00, 8'h80);
		chk({7'h00, srst}, 8'h00);
		wr(7'h01, 8'h80);
		chk({7'h00, p_i}, 8'h01);
		wr(7'h00, 8'h00);
		oe_seen = 1'b0;
		dcp_host_i.xfer(1'b1, 7'h01, 8'h00, q);
		chk({7'h00, oe_seen}, 8'h00);
		$display("done soft");
	endtask : t_soft
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(negedge clk);
		t_rst();
		t_pwr();
		t_txpd();
		t_dly();
		t_lsb();
		t_soft();
		end_sim();
	end
endmodule : dcp_regs_tb
`default_nettype wire
